// >>> logic/strap_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Latch select strap at reset release edges
// - Select 0: shared pin drives 50MHz clock
// - Select 1: shared pin is active-low interrupt
// - Floating select defaults to interrupt mode
// - Clock-output mode suppresses every interrupt indication
// - Link signals timed by the reference clock; here they are sampled and driven on CLK
// - Transmit unbuffered, receive through elasticity buffer
// - Clock-input mode: system supplies 50MHz clock
// - Clock-output mode: 25MHz reference input only
// - Clock-output mode: MAC takes device clock
// - Regulator strap high disables regulator once captured at power-on
// - Regulator strap low enables internal regulator
// - Link LED on with link, blinks on carrier
// - Speed LED on at 100Mbps unless isolated, off otherwise
// - Link LED active-low when regulator strap high
// - Speed LED active-low when select strap high
// - Isolation ignores transmit inputs, keeps management
module strap_device
  import strap_pkg::*;
#(
  parameter int BLINK_COUNT = BLINK_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  strap_link_if.device LINK,
  input wire logic LINK_UP,
  input wire logic SPEED_100,
  input wire logic ISOLATE,
  input wire logic IRQ_PENDING,
  input wire logic TX_EN,
  output logic LINK_ACTIVITY_LED,
  output logic SPEED_LED,
  output logic REGULATOR_ENABLE,
  output logic CLOCK_OUTPUT_MODE,
  output logic TX_ACCEPT
);
  logic sel_sync;
  logic reg_sync;
  logic rst_sync;
  logic carrier_sync;
  logic rst_prev;
  logic sel_latched;
  logic reg_latched;
  logic ref_clk;
  logic [1:0] div_count;
  logic [31:0] blink_count;
  logic blink_phase;
  logic next_link_led;
  logic next_speed_led;
  phase_type phase;
  logic [1:0] strap_wait;
  logic strap_done;

  // Sync resets to pulled-up select level
  level_sync #(.INIT(STRAP_SEL_RESET)) u_sel (
    .CLK(CLK), .RSTN(RSTN), .d(LINK.irq_or_clkout_select_strap), .q(sel_sync));
  level_sync #(.INIT(STRAP_REG_RESET)) u_reg (
    .CLK(CLK), .RSTN(RSTN), .d(LINK.regulator_off_strap), .q(reg_sync));
  level_sync #(.INIT(1'b0)) u_rst (
    .CLK(CLK), .RSTN(RSTN), .d(LINK.hardware_reset_pin_n), .q(rst_sync));
  // Carrier sampled on CLK, not on the divided reference clock
  level_sync #(.INIT(1'b0)) u_crs (
    .CLK(CLK), .RSTN(RSTN), .d(LINK.carrier_valid_pin), .q(carrier_sync));

  // Strap capture phase after power-on
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      phase <= ST_STRAP;
    end else begin
      case (phase)
        ST_STRAP: begin
          if (strap_done) begin
            phase <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!rst_sync) begin
            phase <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (rst_sync) begin
            phase <= ST_RUN;
          end
        end
        default: begin
          phase <= ST_STRAP;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rst_prev <= 1'b0;
    end else begin
      rst_prev <= rst_sync;
    end
  end

  // Synchronisers restart from reset values, so wait until they hold the pins
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      strap_wait <= 2'h0;
    end else if (phase == ST_STRAP && !strap_done) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  assign strap_done = (phase == ST_STRAP) && (strap_wait == 2'(SYNC_STAGES));

  // Capture at power-on and reset rising edge
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sel_latched <= STRAP_SEL_RESET;
    end else if (strap_done || (rst_sync && !rst_prev)) begin
      sel_latched <= sel_sync;
    end
  end

  // Regulator strap sampled at power-on only
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      reg_latched <= STRAP_REG_RESET;
    end else if (strap_done) begin
      reg_latched <= reg_sync;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      div_count <= 2'h0;
      ref_clk <= 1'b0;
    end else if (div_count == 2'(REF_DIV_HALF - 1)) begin
      div_count <= 2'h0;
      ref_clk <= ~ref_clk;
    end else begin
      div_count <= div_count + 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LINK.shared_irq_clock_pin <= 1'b1;
    end else if (!sel_latched) begin
      LINK.shared_irq_clock_pin <= ref_clk;
    end else begin
      LINK.shared_irq_clock_pin <= ~IRQ_PENDING;
    end
  end

  // Blink timer runs while carrier active
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      blink_count <= 32'h0;
      blink_phase <= 1'b0;
    end else if (!carrier_sync) begin
      blink_count <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_count == 32'(BLINK_COUNT - 1)) begin
      blink_count <= 32'h0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_count <= blink_count + 32'h1;
    end
  end

  always_comb begin
    next_link_led = (LINK_UP && !(carrier_sync && blink_phase)) ^ reg_latched;
    next_speed_led = (SPEED_100 && !ISOLATE) ^ sel_latched;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LINK_ACTIVITY_LED <= STRAP_REG_RESET;
      SPEED_LED <= STRAP_SEL_RESET;
    end else begin
      LINK_ACTIVITY_LED <= next_link_led;
      SPEED_LED <= next_speed_led;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      REGULATOR_ENABLE <= 1'b1;
    end else begin
      REGULATOR_ENABLE <= ~reg_latched;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      CLOCK_OUTPUT_MODE <= 1'b0;
    end else begin
      CLOCK_OUTPUT_MODE <= ~sel_latched;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      TX_ACCEPT <= 1'b0;
    end else begin
      TX_ACCEPT <= TX_EN && !ISOLATE;
    end
  end
endmodule

// >>> logic/strap_pkg.sv
package strap_pkg;
  localparam int CLK_MHZ = 200;
  // Reference clock generation: 200 MHz / 4 = 50 MHz
  localparam int REF_DIV_HALF = 2;
  // Blink toggle period in ms
  localparam int BLINK_MS = 50;
  localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
  localparam logic STRAP_SEL_RESET = 1'b1;
  localparam logic STRAP_REG_RESET = 1'b0;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } phase_type;
endpackage

// >>> logic/strap_link_if.sv
`timescale 1ns/1ps
interface strap_link_if;
  logic irq_or_clkout_select_strap;
  logic regulator_off_strap;
  logic shared_irq_clock_pin;
  logic crystal_clock_input;
  logic carrier_valid_pin;
  logic hardware_reset_pin_n;
  modport device (
    input irq_or_clkout_select_strap,
    input regulator_off_strap,
    input crystal_clock_input,
    input carrier_valid_pin,
    input hardware_reset_pin_n,
    output shared_irq_clock_pin
  );
  modport host (
    output irq_or_clkout_select_strap,
    output regulator_off_strap,
    output crystal_clock_input,
    output carrier_valid_pin,
    output hardware_reset_pin_n,
    input shared_irq_clock_pin
  );
endinterface

// >>> logic/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic d,
  output logic q
);
  logic stage;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      stage <= INIT;
      q <= INIT;
    end else begin
      stage <= d;
      q <= stage;
    end
  end
endmodule

// >>> logic/strap_host.sv
`timescale 1ns/1ps
module strap_host
  import strap_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  strap_link_if.host LINK,
  input wire logic SEL_STRAP,
  input wire logic REG_STRAP,
  input wire logic RESET_REQUEST,
  input wire logic CARRIER,
  output logic INTERRUPT_SEEN,
  output logic CLOCK_SEEN
);
  logic shared_sync;
  logic shared_prev;
  logic ref_clk;
  logic [2:0] xtal_count;
  logic [2:0] xtal_half;

  level_sync #(.INIT(1'b1)) u_shared (
    .CLK(CLK), .RSTN(RSTN), .d(LINK.shared_irq_clock_pin), .q(shared_sync));

  // Half period: 50MHz for clock-in, 25MHz for clock-out
  assign xtal_half = SEL_STRAP ? 3'(REF_DIV_HALF) : 3'(2 * REF_DIV_HALF);

  // Host supplies reference on crystal input
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      xtal_count <= 3'h0;
      ref_clk <= 1'b0;
    end else if (xtal_count >= xtal_half - 3'h1) begin
      xtal_count <= 3'h0;
      ref_clk <= ~ref_clk;
    end else begin
      xtal_count <= xtal_count + 3'h1;
    end
  end

  // Strap levels stand through reset, like resistors
  always_ff @(posedge CLK) begin
    LINK.irq_or_clkout_select_strap <= SEL_STRAP;
    LINK.regulator_off_strap <= REG_STRAP;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LINK.hardware_reset_pin_n <= 1'b0;
      LINK.carrier_valid_pin <= 1'b0;
      LINK.crystal_clock_input <= 1'b0;
      shared_prev <= 1'b1;
      INTERRUPT_SEEN <= 1'b0;
      CLOCK_SEEN <= 1'b0;
    end else begin
      LINK.hardware_reset_pin_n <= ~RESET_REQUEST;
      LINK.carrier_valid_pin <= CARRIER;
      LINK.crystal_clock_input <= ref_clk;
      shared_prev <= shared_sync;
      // Clock-output mode: host takes device clock
      CLOCK_SEEN <= shared_sync && !shared_prev && !SEL_STRAP;
      INTERRUPT_SEEN <= !shared_sync && SEL_STRAP;
    end
  end
endmodule

// >>> testbench/strap_link_props.sv
`timescale 1ns/1ps
module strap_link_props #(
  parameter int BLINK_COUNT = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic shared_irq_clock_pin,
  input wire logic carrier_valid_pin,
  input wire logic LINK_UP,
  input wire logic SPEED_100,
  input wire logic ISOLATE,
  input wire logic IRQ_PENDING,
  input wire logic TX_EN,
  input wire logic LINK_ACTIVITY_LED,
  input wire logic SPEED_LED,
  input wire logic REGULATOR_ENABLE,
  input wire logic CLOCK_OUTPUT_MODE,
  input wire logic TX_ACCEPT
);
  localparam int BLINK_MAX = 2 * BLINK_COUNT + 8;
  logic [2:0] age;
  logic up;
  assign up = (age == 3'h7);
  // Settling time after reset release
  always_ff @(posedge CLK) begin
    if (!RSTN) age <= 3'h0;
    else if (!up) age <= age + 3'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence clk_period;
    shared_irq_clock_pin [*2] ##1 !shared_irq_clock_pin [*2] ##1 shared_irq_clock_pin;
  endsequence
  sequence quiet_line;
    !carrier_valid_pin [*6];
  endsequence
  a_tx_pass: assert property (TX_EN && !ISOLATE |=> TX_ACCEPT)
    else $error("transmit not accepted");
  a_tx_block: assert property (ISOLATE |=> !TX_ACCEPT)
    else $error("transmit accepted while isolated");
  a_speed_led: assert property (up && $stable(CLOCK_OUTPUT_MODE) |->
    SPEED_LED == (($past(SPEED_100) && !$past(ISOLATE)) ^ !CLOCK_OUTPUT_MODE))
    else $error("speed indicator wrong");
  a_clk_wave: assert property (up && CLOCK_OUTPUT_MODE && $past(CLOCK_OUTPUT_MODE, 2) &&
    $rose(shared_irq_clock_pin) |-> clk_period)
    else $error("output clock period wrong");
  a_clk_busy: assert property (up && CLOCK_OUTPUT_MODE && $past(CLOCK_OUTPUT_MODE) |->
    ##[1:2] $changed(shared_irq_clock_pin))
    else $error("output clock stalled");
  a_irq_level: assert property (up && !CLOCK_OUTPUT_MODE && !$past(CLOCK_OUTPUT_MODE) |->
    shared_irq_clock_pin == !$past(IRQ_PENDING))
    else $error("interrupt level wrong");
  a_reg_hold: assert property (up |-> $stable(REGULATOR_ENABLE))
    else $error("regulator setting changed");
  a_link_on: assert property (up ##0 quiet_line ##0 LINK_UP && $past(LINK_UP) |->
    LINK_ACTIVITY_LED == REGULATOR_ENABLE)
    else $error("link indicator wrong");
  a_link_blink: assert property (up && LINK_UP ##0 carrier_valid_pin [*4] |->
    ##[1:BLINK_MAX] ($changed(LINK_ACTIVITY_LED) || !carrier_valid_pin))
    else $error("link indicator not blinking");
endmodule

// >>> testbench/strap_refclk_led_control_tb.sv
`timescale 1ns/1ps
module strap_refclk_led_control_tb;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic LINK_UP = 1'b0, SPEED_100 = 1'b0, ISOLATE = 1'b0, IRQ_PENDING = 1'b0, TX_EN = 1'b0;
  logic SEL_STRAP = 1'b1, REG_STRAP = 1'b0, RESET_REQUEST = 1'b0, CARRIER = 1'b0;
  logic lnk_led, spd_led, reg_en, clk_mode, tx_acc, irq_seen, clk_seen, prev;
  int err_count = 0;
  int checked = 0;
  int nc, nl;
  strap_link_if link();
  strap_device #(.BLINK_COUNT(8)) strap_device_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link),
    .LINK_UP(LINK_UP), .SPEED_100(SPEED_100), .ISOLATE(ISOLATE), .IRQ_PENDING(IRQ_PENDING),
    .TX_EN(TX_EN), .LINK_ACTIVITY_LED(lnk_led), .SPEED_LED(spd_led),
    .REGULATOR_ENABLE(reg_en), .CLOCK_OUTPUT_MODE(clk_mode), .TX_ACCEPT(tx_acc));
  strap_host strap_host_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link), .SEL_STRAP(SEL_STRAP),
    .REG_STRAP(REG_STRAP), .RESET_REQUEST(RESET_REQUEST), .CARRIER(CARRIER),
    .INTERRUPT_SEEN(irq_seen), .CLOCK_SEEN(clk_seen));
  strap_link_props #(.BLINK_COUNT(8)) strap_link_props_inst (.CLK(CLK), .RSTN(RSTN),
    .shared_irq_clock_pin(link.shared_irq_clock_pin),
    .carrier_valid_pin(link.carrier_valid_pin), .LINK_UP(LINK_UP), .SPEED_100(SPEED_100),
    .ISOLATE(ISOLATE), .IRQ_PENDING(IRQ_PENDING), .TX_EN(TX_EN),
    .LINK_ACTIVITY_LED(lnk_led), .SPEED_LED(spd_led), .REGULATOR_ENABLE(reg_en),
    .CLOCK_OUTPUT_MODE(clk_mode), .TX_ACCEPT(tx_acc));
  initial forever #2.5 CLK = ~CLK;
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge CLK);
  endtask
  task automatic power_up(input logic sel, input logic rg);
    RSTN = 1'b0;
    SEL_STRAP = sel;
    REG_STRAP = rg;
    wait_cyc(16);
    RSTN = 1'b1;
    wait_cyc(10);
  endtask
  // Clock pulses and indicator changes over k cycles
  task automatic sample(input int k);
    nc = 0;
    nl = 0;
    repeat (k) begin
      prev = lnk_led;
      @(negedge CLK);
      nc += int'(clk_seen === 1'b1);
      nl += int'(lnk_led !== prev);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    close_out();
  end
  initial begin
    power_up(1'b1, 1'b0);
    chk(clk_mode, 1'b0);
    chk(reg_en, 1'b1);
    {IRQ_PENDING, LINK_UP, SPEED_100, TX_EN} = 4'hf;
    wait_cyc(6);
    chk(irq_seen, 1'b1);
    chk(spd_led, 1'b0);
    chk(lnk_led, 1'b1);
    chk(tx_acc, 1'b1);
    ISOLATE = 1'b1;
    wait_cyc(2);
    chk(spd_led, 1'b1);
    chk(tx_acc, 1'b0);
    ISOLATE = 1'b0;
    SEL_STRAP = 1'b0;
    REG_STRAP = 1'b1;
    RESET_REQUEST = 1'b1;
    wait_cyc(4);
    RESET_REQUEST = 1'b0;
    wait_cyc(10);
    chk(clk_mode, 1'b1);
    chk(reg_en, 1'b1);
    sample(16);
    chk_n(nc, 4);
    power_up(1'b0, 1'b1);
    chk(reg_en, 1'b0);
    chk(lnk_led, 1'b0);
    chk(spd_led, 1'b1);
    CARRIER = 1'b1;
    sample(40);
    chk(logic'(nl >= 3), 1'b1);
    CARRIER = 1'b0;
    wait_cyc(8);
    chk(lnk_led, 1'b0);
    close_out();
  end
endmodule
